/* File: design/mdm_device.sv */
// Transceiver end of the serial management port, two channels of registers.
// Assumes the link clock is slow enough for several system clocks per half period.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_cfg.svh"

module mdm_device (
    input  wire logic  i_ref_clk,
    input  wire logic  i_sys_rst,
    mdm_if.device      link,
    output logic       o_synced,
    output logic       o_bcast_en
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mdm_pkg::mdm_dev_state_t state;
        logic [5:0]              cnt;
        logic [13:0]             hdr;
        logic [15:0]             shift;
        logic                    mdc_d;
        logic                    is_read;
        logic                    hit;
        logic                    chan;
        logic                    drive;
        logic                    dout;
        logic                    synced;
    } mdm_dev_st_t;

    mdm_dev_st_t st_reg;
    mdm_dev_st_t st_next;

    logic [15:0] regs_a [0:31];
    logic [15:0] regs_b [0:31];
    logic        mdc_s;
    logic        mdio_s;
    logic        rise;
    logic        fall;
    logic        wr_en;
    logic        wr_a;
    logic        wr_b;
    logic [4:0]  wr_addr;
    logic [15:0] wr_data;
    logic        bcast;

    mdm_sync2 u_sync_mdc (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (link.mdc),
        .o_sync    (mdc_s)
    );

    mdm_sync2 u_sync_mdio (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (link.mdio),
        .o_sync    (mdio_s)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address match against either channel
    function automatic logic addr_hit(input logic [4:0] a);
        addr_hit = (a == `MDM_CHAN_A_ADDR) || (a == `MDM_CHAN_B_ADDR);
    endfunction : addr_hit

    // Read value, status bit 6 forced high
    function automatic logic [15:0] rd_val(input logic [15:0] v, input logic [4:0] a);
        rd_val = v;
        if (a == `MDM_REG_STATUS) begin
            rd_val[`MDM_STATUS_PS_BIT] = 1'b1;
        end
    endfunction : rd_val

    assign rise  = mdc_s && !st_reg.mdc_d;
    assign fall  = !mdc_s && st_reg.mdc_d;
    assign bcast = regs_a[`MDM_REG_BYPASS][`MDM_BYPASS_SW_BIT];

    // ------------------------------------------------------------
    // Frame receiver
    // ------------------------------------------------------------
    // Bits taken on rising edges; drive changes on falling edges
    always_comb begin
        st_next       = st_reg;
        st_next.mdc_d = mdc_s;
        wr_en         = 1'b0;
        wr_addr       = st_reg.hdr[4:0];
        wr_data       = {st_reg.shift[14:0], mdio_s};
        if (rise) begin
            unique case (st_reg.state)
                mdm_pkg::MDM_D_UNSYNC: begin
                    // Count consecutive ones; any zero restarts
                    if (!mdio_s) begin
                        st_next.cnt = 6'd0;
                    end else if (st_reg.cnt == `MDM_PREAMBLE_BITS - 6'd1) begin
                        st_next.state  = mdm_pkg::MDM_D_IDLE;
                        st_next.synced = 1'b1;
                        st_next.cnt    = 6'd0;
                    end else begin
                        st_next.cnt = st_reg.cnt + 6'd1;
                    end
                end
                mdm_pkg::MDM_D_IDLE: begin
                    // First zero after idle ones opens a frame
                    if (!mdio_s) begin
                        st_next.state = mdm_pkg::MDM_D_HDR;
                        st_next.cnt   = 6'd0;
                        st_next.hdr   = 14'h0000;
                    end
                end
                mdm_pkg::MDM_D_HDR: begin
                    // Second start bit, opcode, two addresses, MSB first
                    st_next.hdr = {st_reg.hdr[12:0], mdio_s};
                    st_next.cnt = st_reg.cnt + 6'd1;
                    if (st_reg.cnt == 6'd0 && !mdio_s) begin
                        st_next.state  = mdm_pkg::MDM_D_UNSYNC;
                        st_next.synced = 1'b0;
                        st_next.cnt    = 6'd0;
                    end else if (st_reg.cnt == 6'd2 &&
                                 ({st_reg.hdr[0], mdio_s} != `MDM_OP_READ) &&
                                 ({st_reg.hdr[0], mdio_s} != `MDM_OP_WRITE)) begin
                        st_next.state  = mdm_pkg::MDM_D_UNSYNC;
                        st_next.synced = 1'b0;
                        st_next.cnt    = 6'd0;
                    end else if (st_reg.cnt == 6'd12) begin
                        st_next.state   = mdm_pkg::MDM_D_TA;
                        st_next.cnt     = 6'd0;
                        st_next.is_read = (st_reg.hdr[10:9] == `MDM_OP_READ);
                        st_next.hit     = addr_hit(st_reg.hdr[8:4]);
                        st_next.chan    = (st_reg.hdr[8:4] == `MDM_CHAN_B_ADDR);
                        st_next.shift   = (st_reg.hdr[8:4] == `MDM_CHAN_B_ADDR)
                                        ? rd_val(regs_b[{st_reg.hdr[3:0], mdio_s}], {st_reg.hdr[3:0], mdio_s})
                                        : rd_val(regs_a[{st_reg.hdr[3:0], mdio_s}], {st_reg.hdr[3:0], mdio_s});
                    end
                end
                mdm_pkg::MDM_D_TA: begin
                    // Write turnaround must be one then zero
                    st_next.cnt = st_reg.cnt + 6'd1;
                    if (!st_reg.is_read && (mdio_s != (st_reg.cnt == 6'd0))) begin
                        st_next.state  = mdm_pkg::MDM_D_UNSYNC;
                        st_next.synced = 1'b0;
                        st_next.cnt    = 6'd0;
                    end else if (st_reg.cnt == 6'd1) begin
                        st_next.state = mdm_pkg::MDM_D_DATA;
                        st_next.cnt   = 6'd0;
                    end
                end
                mdm_pkg::MDM_D_DATA: begin
                    st_next.cnt = st_reg.cnt + 6'd1;
                    if (!st_reg.is_read) begin
                        st_next.shift = {st_reg.shift[14:0], mdio_s};
                    end
                    if (st_reg.cnt == `MDM_DATA_BITS - 6'd1) begin
                        st_next.state = mdm_pkg::MDM_D_DONE;
                        wr_en         = !st_reg.is_read && st_reg.hit;
                    end
                end
                mdm_pkg::MDM_D_DONE: begin
                    // One idle bit then a new frame may start
                    st_next.state = mdm_pkg::MDM_D_IDLE;
                end
            endcase
        end
        // Read drive: release in first TA bit, zero in second, then data
        if (fall) begin
            if (st_reg.state == mdm_pkg::MDM_D_TA && st_reg.cnt == 6'd1 &&
                st_reg.is_read && st_reg.hit) begin
                st_next.drive = 1'b1;
                st_next.dout  = 1'b0;
            end else if (st_reg.state == mdm_pkg::MDM_D_DATA && st_reg.is_read && st_reg.hit) begin
                st_next.drive = 1'b1;
                st_next.dout  = st_reg.shift[15];
                st_next.shift = {st_reg.shift[14:0], 1'b0};
            end else begin
                st_next.drive = 1'b0;
            end
        end
    end

    // Channel A writes mirror to B while broadcast is set
    assign wr_a = wr_en && !st_reg.chan;
    assign wr_b = wr_en && (st_reg.chan || bcast);

    // ------------------------------------------------------------
    // State and register banks
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{state: mdm_pkg::MDM_D_UNSYNC, mdc_d: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Only the bypass words reset, so broadcast starts off; other words stay unknown until written
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            regs_a[`MDM_REG_BYPASS] <= 16'h0000;
            regs_b[`MDM_REG_BYPASS] <= 16'h0000;
        end else begin
            if (wr_a) begin
                regs_a[wr_addr] <= wr_data;
            end
            if (wr_b) begin
                regs_b[wr_addr] <= wr_data;
            end
        end
    end

    assign link.dev_dout = st_reg.dout;
    assign link.dev_oe_n = !st_reg.drive;
    assign o_synced      = st_reg.synced;
    assign o_bcast_en    = bcast;
endmodule : mdm_device

`default_nettype wire

/* File: design/mdm_station.sv */
// Station end: makes the link clock and runs one read or write per request.
// Assumes requests are held until o_done.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_cfg.svh"

module mdm_station (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    mdm_if.station           link,
    input  wire logic        i_req,
    input  wire logic        i_read,
    input  wire logic        i_preamble,
    input  wire logic [4:0]  i_phy_addr,
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [15:0] i_wdata,
    output logic             o_busy,
    output logic             o_done,
    output logic [15:0]      o_rdata
);
    typedef struct packed {
        mdm_pkg::mdm_sta_state_t state;
        logic [7:0]              div;
        logic                    mdc;
        logic [5:0]              cnt;
        logic [31:0]             sh;
        logic                    rd;
        logic                    dout;
        logic                    oe_n;
        logic [15:0]             rdata;
    } mdm_sta_st_t;

    mdm_sta_st_t st_reg;
    mdm_sta_st_t st_next;
    logic        mdio_s;
    logic        tick;

    mdm_sync2 u_sync_mdio (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (link.mdio),
        .o_sync    (mdio_s)
    );

    assign tick = (st_reg.div == 8'(`MDM_MDC_HALF_CYC - 1));

    // ------------------------------------------------------------
    // Sequencer: change data on falling edge, sample read on rising
    // ------------------------------------------------------------
    always_comb begin
        st_next     = st_reg;
        st_next.div = tick ? 8'd0 : st_reg.div + 8'd1;
        if (tick) begin
            st_next.mdc = !st_reg.mdc;
        end
        if (st_reg.state == mdm_pkg::MDM_S_DONE) begin
            st_next.state = mdm_pkg::MDM_S_IDLE;
        end else if (st_reg.state == mdm_pkg::MDM_S_IDLE && i_req) begin
            st_next.state = i_preamble ? mdm_pkg::MDM_S_PRE : mdm_pkg::MDM_S_SHIFT;
            st_next.cnt   = 6'd0;
            st_next.rd    = i_read;
            // Start, op, addrs, TA, data; read TA/data left released
            st_next.sh    = {`MDM_START_PAT, i_read ? `MDM_OP_READ : `MDM_OP_WRITE,
                             i_phy_addr, i_reg_addr, `MDM_TA_WRITE, i_wdata};
        end else if (tick && st_reg.mdc) begin
            // Falling edge: present next bit
            unique case (st_reg.state)
                mdm_pkg::MDM_S_PRE: begin
                    st_next.oe_n = 1'b0;
                    st_next.dout = 1'b1;
                    st_next.cnt  = st_reg.cnt + 6'd1;
                    if (st_reg.cnt == `MDM_PREAMBLE_BITS - 6'd1) begin
                        st_next.state = mdm_pkg::MDM_S_SHIFT;
                        st_next.cnt   = 6'd0;
                    end
                end
                mdm_pkg::MDM_S_SHIFT: begin
                    st_next.dout = st_reg.sh[31];
                    st_next.sh   = {st_reg.sh[30:0], 1'b0};
                    st_next.oe_n = st_reg.rd && (st_reg.cnt >= `MDM_HDR_BITS);
                    st_next.cnt  = st_reg.cnt + 6'd1;
                    if (st_reg.cnt == 6'd32) begin
                        st_next.oe_n  = 1'b1;
                        st_next.state = mdm_pkg::MDM_S_GAP;
                    end
                end
                mdm_pkg::MDM_S_GAP: begin
                    st_next.state = mdm_pkg::MDM_S_DONE;
                end
                default: begin
                    st_next.state = st_reg.state;
                end
            endcase
        end else if (tick && !st_reg.mdc && st_reg.state == mdm_pkg::MDM_S_SHIFT &&
                     st_reg.rd && st_reg.cnt > 6'd16) begin
            st_next.rdata = {st_reg.rdata[14:0], mdio_s};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{state: mdm_pkg::MDM_S_IDLE, oe_n: 1'b1, dout: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.mdc      = st_reg.mdc;
    assign link.sta_dout = st_reg.dout;
    assign link.sta_oe_n = st_reg.oe_n;
    assign o_busy        = (st_reg.state != mdm_pkg::MDM_S_IDLE);
    assign o_done        = (st_reg.state == mdm_pkg::MDM_S_DONE);
    assign o_rdata       = st_reg.rdata;
endmodule : mdm_station

`default_nettype wire

/* File: design/mdm_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes nothing of its input's timing.
`timescale 1ns/1ps
`default_nettype none

module mdm_sync2 (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    typedef struct packed {
        logic meta;
        logic sync;
    } mdm_sync_st_t;

    mdm_sync_st_t st_reg;
    mdm_sync_st_t st_next;

    // First stage read only by the second
    always_comb begin
        st_next      = st_reg;
        st_next.meta = i_async;
        st_next.sync = st_reg.meta;
    end

    // Idle level of the link is high
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{meta: 1'b1, sync: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.sync;
endmodule : mdm_sync2

`default_nettype wire

/* File: include/mdm_cfg.svh */
// Constants for the serial management port: frame layout, register map, timing.
// Assumes inclusion by bare name from package and design files.
`ifndef MDM_CFG_SVH
`define MDM_CFG_SVH

// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define MDM_PREAMBLE_BITS   6'd32
`define MDM_OP_READ         2'b10
`define MDM_OP_WRITE        2'b01
`define MDM_START_PAT       2'b01
`define MDM_TA_WRITE        2'b10
`define MDM_ADDR_W          5
`define MDM_DATA_W          16
`define MDM_HDR_BITS        6'd14
`define MDM_DATA_BITS       6'd16

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define MDM_REG_CTRL        5'h00
`define MDM_REG_STATUS      5'h01
`define MDM_REG_BYPASS      5'h17
`define MDM_STATUS_PS_BIT   6
`define MDM_BYPASS_SW_BIT   15
`define MDM_STATUS_RST      16'h7849
`define MDM_CHAN_A_ADDR     5'h0c
`define MDM_CHAN_B_ADDR     5'h0d

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MDM_CLK_PERIOD_NS   10
`define MDM_MDC_HALF_NS     200
`define MDM_MDC_HALF_CYC    (`MDM_MDC_HALF_NS / `MDM_CLK_PERIOD_NS)

`endif

/* File: include/mdm_if.sv */
// Two-wire management link between station and transceiver.
// Resolves the data wire itself from the two enables (pull-up when neither drives).
`timescale 1ns/1ps
`default_nettype none

interface mdm_if;
    logic mdc;        // Clock, made by the station
    logic sta_dout;   // Station data out
    logic sta_oe_n;   // Station drives when low
    logic dev_dout;   // Device data out
    logic dev_oe_n;   // Device drives when low
    logic mdio;       // Resolved line level

    // Open wire with pull-up
    assign mdio = (!sta_oe_n) ? sta_dout : ((!dev_oe_n) ? dev_dout : 1'b1);

    modport station (output mdc, output sta_dout, output sta_oe_n, input mdio);
    modport device  (input mdc, output dev_dout, output dev_oe_n, input mdio);
endinterface : mdm_if

`default_nettype wire

/* File: include/mdm_pkg.sv */
// Types shared by both ends of the serial management port.
// Assumes mdm_cfg.svh on the include path.
`include "mdm_cfg.svh"

package mdm_pkg;

    // --------------------------------------------------------
    // Device receive states
    // --------------------------------------------------------
    typedef enum logic [5:0] {
        MDM_D_UNSYNC = 6'h01,
        MDM_D_IDLE   = 6'h02,
        MDM_D_HDR    = 6'h04,
        MDM_D_TA     = 6'h08,
        MDM_D_DATA   = 6'h10,
        MDM_D_DONE   = 6'h20
    } mdm_dev_state_t;

    // --------------------------------------------------------
    // Station transmit states
    // --------------------------------------------------------
    typedef enum logic [4:0] {
        MDM_S_IDLE  = 5'h01,
        MDM_S_PRE   = 5'h02,
        MDM_S_SHIFT = 5'h04,
        MDM_S_GAP   = 5'h08,
        MDM_S_DONE  = 5'h10
    } mdm_sta_state_t;

endpackage : mdm_pkg

/* File: sim/mdm_link_props.sv */
// Checker on the management link wires between the two ends.
// Assumes plain copies of the interface signals and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module mdm_link_props (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic mdc,
    input wire logic sta_dout,
    input wire logic sta_oe_n,
    input wire logic dev_dout,
    input wire logic dev_oe_n,
    input wire logic mdio
);
    logic       mdc_d_reg;
    logic [5:0] run_reg;
    logic [9:0] rel_reg;
    logic [9:0] drv_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // Run lengths; reset counts as long idle so the first rise passes
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mdc_d_reg <= 1'b0;
            run_reg   <= 6'h3f;
            rel_reg   <= 10'h000;
            drv_reg   <= 10'h000;
        end else begin
            mdc_d_reg <= mdc;
            run_reg   <= (mdc != mdc_d_reg) ? 6'h01 : ((run_reg == 6'h3f) ? run_reg : run_reg + 6'h01);
            rel_reg   <= !(sta_oe_n && dev_oe_n) ? 10'h000 : ((rel_reg == 10'h3ff) ? rel_reg : rel_reg + 10'h001);
            drv_reg   <= dev_oe_n ? 10'h000 : drv_reg + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Read turnaround steps
    // ------------------------------------------------------------
    sequence s_dev_take;
        $fell(dev_oe_n);
    endsequence

    sequence s_ta_zero;
        (!dev_oe_n && !dev_dout) [*8];
    endsequence

    chk_no_contend: assert property (!(!sta_oe_n && !dev_oe_n))
        else $error("both ends drive the data line");
    chk_ta_undriven: assert property (s_dev_take |-> rel_reg >= 10'd38 && rel_reg <= 10'd48)
        else $error("first turnaround bit not left to the pull-up");
    chk_ta_zero: assert property (s_dev_take |-> s_ta_zero)
        else $error("device turnaround bit not zero");
    chk_read_length: assert property ($rose(dev_oe_n) |-> drv_reg >= 10'd670 && drv_reg <= 10'd690)
        else $error("device drive not seventeen bit times");
    chk_release_low: assert property ($rose(dev_oe_n) |-> !mdc)
        else $error("device released line outside a low half");
    chk_dev_setup: assert property (($changed(dev_dout) && !dev_oe_n && $past(!dev_oe_n)) |-> !mdc)
        else $error("device data moved while clock high");
    chk_sta_setup: assert property (($changed(sta_dout) && !sta_oe_n) |-> !mdc)
        else $error("station data moved while clock high");
    chk_mdc_high: assert property ($fell(mdc) |-> run_reg == 6'd20)
        else $error("clock high half not twenty cycles");
    chk_mdc_low: assert property ($rose(mdc) |-> run_reg >= 6'd20)
        else $error("clock low half too short");
    chk_idle_pull: assert property ((sta_oe_n && dev_oe_n) |-> mdio)
        else $error("released line not high");
endmodule : mdm_link_props

`default_nettype wire

/* File: sim/tb_top.sv */
// Bench: station and device face each other on one link; a second device
// sits on a link driven bit by bit from here to feed it faulty frames.
// Assumes the design files, the interface and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_cfg.svh"
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin failures++; \
    $display("BAD %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
    localparam logic [4:0] chan_a = `MDM_CHAN_A_ADDR;
    localparam logic [4:0] chan_b = `MDM_CHAN_B_ADDR;
    logic        i_ref_clk, i_sys_rst;
    logic        req, rd, pre, busy, done;
    logic [4:0]  phy, rega;
    logic [15:0] wdata, rdata;
    logic        synced, bcast, synced2, bcast2;
    logic [64:0] wire_q = '0;
    int          rises = 0;
    int          cyc = 0;
    int          failures, n_compared;

    mdm_if mdm_if_i ();
    mdm_if mdm_if_i2 ();
    mdm_station mdm_station_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(mdm_if_i),
        .i_req(req), .i_read(rd), .i_preamble(pre), .i_phy_addr(phy), .i_reg_addr(rega),
        .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata));
    mdm_device mdm_device_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(mdm_if_i),
        .o_synced(synced), .o_bcast_en(bcast));
    mdm_device mdm_device_i2 (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(mdm_if_i2),
        .o_synced(synced2), .o_bcast_en(bcast2));
    mdm_link_props mdm_link_props_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .mdc(mdm_if_i.mdc),
        .sta_dout(mdm_if_i.sta_dout), .sta_oe_n(mdm_if_i.sta_oe_n), .dev_dout(mdm_if_i.dev_dout),
        .dev_oe_n(mdm_if_i.dev_oe_n), .mdio(mdm_if_i.mdio));

    // 100 MHz system clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Wire monitor: line level at each link clock rise
    always @(posedge mdm_if_i.mdc) begin
        wire_q <= {wire_q[63:0], mdm_if_i.mdio};
        rises <= rises + 1;
    end

    // Hang guard, well above the whole run
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // One station transfer; checks the bits seen on the wire too
    task automatic xfer(input logic r, input logic p, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] ed);
        int          n;
        int          k;
        logic [1:0]  ta;
        logic [64:0] g;
        @(posedge i_ref_clk);
        #1;
        ta = (r && pa != chan_a && pa != chan_b) ? 2'b11 : `MDM_TA_WRITE;
        k = rises + (p ? 64 : 32);
        req = 1'b1;
        rd = r;
        pre = p;
        phy = pa;
        rega = ra;
        wdata = r ? ~ed : ed;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        `CHK("done", 1'b1, done)
        req = 1'b0;
        // Newest rise is the idle bit after the frame; one more rise may come before the first bit
        g = wire_q >> 1;
        `CHK("bit count", 1'b1, (rises == k + 1 || rises == k + 2))
        `CHK("frame", {2'b01, (r ? `MDM_OP_READ : `MDM_OP_WRITE), pa, ra, ta, ed}, g[31:0])
        if (p) `CHK("preamble", 32'hffffffff, g[63:32])
        if (r) `CHK("rdata", ed, rdata)
    endtask : xfer

    // Bench-made link clock, 80 ns a bit; data moves with the falling edge
    task automatic send(input logic [31:0] v, input int n, input logic drv);
        for (int i = n - 1; i >= 0; i--) begin
            mdm_if_i2.sta_oe_n = !drv;
            mdm_if_i2.sta_dout = v[i];
            repeat (4) @(posedge i_ref_clk);
            #1 mdm_if_i2.mdc = 1'b1;
            repeat (4) @(posedge i_ref_clk);
            #1 mdm_if_i2.mdc = 1'b0;
        end
        repeat (8) @(posedge i_ref_clk);
        #1;
    endtask : send

    task automatic t_reset();
        `CHK("synced", 1'b0, synced)
        `CHK("busy", 1'b0, busy)
        `CHK("bcast", 1'b0, bcast)
        $display("test reset done");
    endtask : t_reset

    task automatic t_rw();
        xfer(1'b0, 1'b1, chan_a, 5'h00, 16'ha5c3);
        `CHK("synced", 1'b1, synced)
        xfer(1'b1, 1'b0, chan_a, 5'h00, 16'ha5c3);
        xfer(1'b0, 1'b0, chan_b, 5'h1f, 16'h3c5a);
        xfer(1'b1, 1'b0, chan_b, 5'h1f, 16'h3c5a);
        xfer(1'b1, 1'b0, chan_a, 5'h00, 16'ha5c3);
        xfer(1'b0, 1'b0, chan_a, `MDM_REG_STATUS, 16'h0000);
        xfer(1'b1, 1'b0, chan_a, `MDM_REG_STATUS, 16'h0040);
        xfer(1'b1, 1'b0, 5'h05, 5'h00, 16'hffff);
        $display("test read write done");
    endtask : t_rw

    task automatic t_bcast();
        xfer(1'b0, 1'b0, chan_a, 5'h04, 16'h1111);
        xfer(1'b0, 1'b0, chan_b, 5'h04, 16'h2222);
        xfer(1'b0, 1'b0, chan_a, `MDM_REG_BYPASS, 16'h8000);
        `CHK("bcast", 1'b1, bcast)
        xfer(1'b0, 1'b0, chan_a, 5'h05, 16'habcd);
        xfer(1'b1, 1'b0, chan_b, 5'h05, 16'habcd);
        xfer(1'b1, 1'b0, chan_a, 5'h04, 16'h1111);
        xfer(1'b1, 1'b0, chan_b, 5'h04, 16'h2222);
        xfer(1'b0, 1'b0, chan_a, `MDM_REG_BYPASS, 16'h0000);
        `CHK("bcast", 1'b0, bcast)
        xfer(1'b0, 1'b0, chan_a, 5'h05, 16'h5555);
        xfer(1'b1, 1'b0, chan_b, 5'h05, 16'habcd);
        $display("test broadcast done");
    endtask : t_bcast

    // Mid-run reset: writes before a new preamble must not land
    task automatic t_rst2();
        @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b1;
        repeat (12) @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b0;
        `CHK("synced", 1'b0, synced)
        xfer(1'b0, 1'b0, chan_a, 5'h00, 16'h0000);
        xfer(1'b1, 1'b1, chan_a, 5'h00, 16'ha5c3);
        $display("test second reset done");
    endtask : t_rst2

    // Second link: bad start, both bad opcodes and a bad write turnaround
    task automatic t_fault();
        logic [15:0] bad [4] = '{{2'b00, 2'b01, chan_a, 5'h02, 2'b10}, {2'b01, 2'b11, chan_a, 5'h02, 2'b10},
                                 {2'b01, 2'b00, chan_a, 5'h02, 2'b10}, {2'b01, 2'b01, chan_a, 5'h02, 2'b00}};
        send({2'b01, 2'b01, chan_a, 5'h02, 2'b10, 16'h1234}, 32, 1'b1);
        `CHK("synced2", 1'b0, synced2)
        for (int i = 0; i < 4; i++) begin
            send(32'hffffffff, 32, 1'b0);
            `CHK("synced2", 1'b1, synced2)
            send({2'b01, 2'b01, chan_a, 5'h02, 2'b10, 16'h1234}, 32, 1'b1);
            send(32'hffffffff, 1, 1'b0);
            `CHK("synced2", 1'b1, synced2)
            send({bad[i], 16'h0000}, 32, 1'b1);
            `CHK("synced2", 1'b0, synced2)
        end
        `CHK("bcast2", 1'b0, bcast2)
        $display("test fault frames done");
    endtask : t_fault

    // Main sequence
    initial begin
        {req, rd, pre, phy, rega, wdata} = '0;
        i_sys_rst = 1'b1;
        mdm_if_i2.mdc = 1'b0;
        mdm_if_i2.sta_dout = 1'b1;
        mdm_if_i2.sta_oe_n = 1'b1;
        {failures, n_compared} = '0;
        repeat (12) @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b0;
        t_reset();
        t_rw();
        t_bcast();
        t_rst2();
        t_fault();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
